// File: shared/dma_defs.svh
// How it works
// - four channels, each configured on its own
// - block length one byte to 64K bytes
// - repeat count stretches transaction to 16M bytes
// - source, destination step up, down or static
// - reload restores start addresses on completion
// - bursts of one, two, four, eight bytes
// - linked pair: each arms other at completion
// - never write nonvolatile window, no program space
// - every byte access waits for bus grant
// - fixed grant order shared with processor
// - per-channel trigger: software, peripheral, event
// - pending channels served by programmable priority
// - source any memory or register address; destination any outside nonvolatile window
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NCH        4
`define AW         16
`define BUF_DEPTH  8

// ----------------------------------------------------------------
// address step modes
// ----------------------------------------------------------------
`define AM_STATIC  2'h0
`define AM_INC     2'h1
`define AM_DEC     2'h2

// ----------------------------------------------------------------
// burst codes, last byte index of each
// ----------------------------------------------------------------
`define BL_1       3'h0
`define BL_2       3'h1
`define BL_4       3'h3
`define BL_8       3'h7

// ----------------------------------------------------------------
// trigger select code for the software strobe
// ----------------------------------------------------------------
`define TRIG_SW    2'h0

// ----------------------------------------------------------------
// mapped nonvolatile storage window in data space
// ----------------------------------------------------------------
`define EE_FIRST   16'h1000
`define EE_LAST    16'h1fff

`endif

// File: shared/dma_pkg.sv
package dma_pkg;

`include "dma_defs.svh"

    // controller sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_RCAP,
        ST_WPREP,
        ST_WLOAD,
        ST_WRITE
    } dma_state_t;

    // whole controller state
    typedef struct packed {
        dma_state_t                 st;    // sequencer
        logic [1:0]                 ch;    // channel in service
        logic [2:0]                 idx;   // byte index within burst
        logic [2:0]                 last;  // last index of burst
        logic [`NCH-1:0][`AW-1:0]   src;   // current source address
        logic [`NCH-1:0][`AW-1:0]   dst;   // current destination
        logic [`NCH-1:0][16:0]      blk;   // bytes left in block
        logic [`NCH-1:0][8:0]       rep;   // blocks left
        logic [`NCH-1:0]            act;   // transaction armed
        logic [`NCH-1:0]            pend;  // trigger waiting
        logic [`NCH-1:0]            done;  // sticky completion
        logic [`NCH-1:0]            err;   // sticky abort
        logic                       req;   // bus request
        logic                       we;    // bus write
        logic [`AW-1:0]             addr;  // bus address
        logic [7:0]                 wdata; // bus write data
    } dma_regs_t;

    // burst buffer state
    typedef struct packed {
        logic [`BUF_DEPTH-1:0][7:0] mem;
        logic [7:0]                 rd;
    } buf_regs_t;

endpackage

// File: rtl/dma_burst_buf.sv
`timescale 1ns/1ps
`include "dma_defs.svh"
module dma_burst_buf
    import dma_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // write side
    input  wire logic       wr_en_in,
    input  wire logic [2:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    // read side, one cycle latency
    input  wire logic [2:0] rd_addr_in,
    output logic      [7:0] rd_data_out
);

    buf_regs_t r;    // registered state
    buf_regs_t r_nxt; // next state

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_nxt = r;
        // store one byte
        if (wr_en_in) begin
            r_nxt.mem[wr_addr_in] = wr_data_in;
        end
        // registered read port
        r_nxt.rd = r.mem[rd_addr_in];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign rd_data_out = r.rd;

endmodule

// File: rtl/dma_controller.sv
`timescale 1ns/1ps
`include "dma_defs.svh"
module dma_controller
    import dma_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    // per-channel configuration, then pair link enables and priority mode
    input  wire logic [`NCH-1:0][`AW-1:0] cfg_src_in,
    input  wire logic [`NCH-1:0][`AW-1:0] cfg_dst_in,
    input  wire logic [`NCH-1:0][15:0]    cfg_blk_in,
    input  wire logic [`NCH-1:0][7:0]     cfg_rep_in,
    input  wire logic [`NCH-1:0][1:0]     src_mode_in,
    input  wire logic [`NCH-1:0][1:0]     dst_mode_in,
    input  wire logic [`NCH-1:0][1:0]     burst_in,
    input  wire logic [`NCH-1:0]          reload_in,
    input  wire logic [`NCH-1:0][1:0]     trig_sel_in,
    input  wire logic [1:0]               link_in,
    input  wire logic                     prio_rr_in,
    // per-channel control strobes
    input  wire logic [`NCH-1:0]          arm_in,
    input  wire logic [`NCH-1:0]          sw_trig_in,
    input  wire logic [`NCH-1:0][2:0]     chan_trig_in,
    input  wire logic [`NCH-1:0]          done_clr_in,
    // shared data bus master
    input  wire logic                     bus_gnt_in,
    input  wire logic [7:0]               bus_rdata_in,
    output logic                          bus_req_out,
    output logic                          bus_we_out,
    output logic      [`AW-1:0]           bus_addr_out,
    output logic      [7:0]               bus_wdata_out,
    // status
    output logic      [`NCH-1:0]          busy_out,
    output logic      [`NCH-1:0]          done_out,
    output logic      [`NCH-1:0]          err_out,
    output logic      [1:0]               cur_ch_out
);

    dma_regs_t        r;        // registered state
    dma_regs_t        r_nxt;    // next state
    logic [`NCH-1:0]  trig_hit; // selected trigger per channel
    logic             fin;      // transaction completes this cycle
    logic             buf_we;   // buffer write strobe
    logic [2:0]       buf_ra;   // buffer read index
    logic [7:0]       buf_rd;   // buffer read data

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // address step after each byte
    function automatic logic [`AW-1:0] step(input logic [`AW-1:0] a, input logic [1:0] m);
        unique case (m)
            `AM_INC: step = `AW'(a + `AW'h1);
            `AM_DEC: step = `AW'(a - `AW'h1);
            default: step = a;
        endcase
    endfunction

    // last byte index for a burst code
    function automatic logic [2:0] burst_last(input logic [1:0] b);
        unique case (b)
            2'h0: burst_last = `BL_1;
            2'h1: burst_last = `BL_2;
            2'h2: burst_last = `BL_4;
            2'h3: burst_last = `BL_8;
        endcase
    endfunction

    // inside the mapped nonvolatile window
    function automatic logic in_ee(input logic [`AW-1:0] a);
        in_ee = (a >= `EE_FIRST) && (a <= `EE_LAST);
    endfunction

    // fixed order from channel 0, or rotating after the last served
    function automatic logic [2:0] pick(input logic [3:0] el, input logic [1:0] lst,
                                        input logic rr);
        logic [1:0] k;
        pick = 3'h0;
        for (int i = `NCH - 1; i >= 0; i--) begin
            k = rr ? 2'(lst + 2'(i) + 2'h1) : 2'(i);
            if (el[k]) begin
                pick = {1'b1, k};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // trigger selection, one per channel
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NCH; g++) begin : g_trig
            assign trig_hit[g] = (trig_sel_in[g] == `TRIG_SW) ? sw_trig_in[g]
                               : chan_trig_in[g][2'(trig_sel_in[g] - 2'h1)];
        end
    endgenerate

    // ----------------------------------------------------------------
    // burst buffer
    // ----------------------------------------------------------------
    dma_burst_buf i_dma_burst_buf (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (buf_we),
        .wr_addr_in  (r.idx),
        .wr_data_in  (bus_rdata_in),
        .rd_addr_in  (buf_ra),
        .rd_data_out (buf_rd)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] c;
        logic [1:0] p;
        logic [2:0] sel;
        r_nxt  = r;
        fin    = 1'b0;
        buf_we = 1'b0;
        buf_ra = r.idx;
        c      = r.ch;
        p      = r.ch ^ 2'h1;
        sel    = pick(r.act & r.pend, r.ch, prio_rr_in);
        // software clears first so a same-cycle completion wins
        r_nxt.done = r.done & ~done_clr_in;
        for (int i = 0; i < `NCH; i++) begin
            if (arm_in[i] && !r.act[i]) begin
                r_nxt.act[i] = 1'b1;
                r_nxt.err[i] = 1'b0;
                r_nxt.src[i] = cfg_src_in[i];
                r_nxt.dst[i] = cfg_dst_in[i];
                r_nxt.blk[i] = {~|cfg_blk_in[i], cfg_blk_in[i]};
                r_nxt.rep[i] = {~|cfg_rep_in[i], cfg_rep_in[i]};
            end
        end
        unique case (r.st)
            // wait for an armed and triggered channel
            ST_IDLE: begin
                if (sel[2]) begin
                    r_nxt.ch            = sel[1:0];
                    r_nxt.pend[sel[1:0]] = 1'b0;
                    r_nxt.idx           = 3'h0;
                    // burst length, cut at block end
                    r_nxt.last = (r.blk[sel[1:0]] <= 17'(burst_last(burst_in[sel[1:0]])))
                               ? 3'(r.blk[sel[1:0]] - 17'h1) : burst_last(burst_in[sel[1:0]]);
                    r_nxt.req  = 1'b1;
                    r_nxt.we   = 1'b0;
                    r_nxt.addr = r.src[sel[1:0]];
                    r_nxt.st   = ST_READ;
                end
            end
            // read request stands until granted
            ST_READ: begin
                if (bus_gnt_in) begin
                    r_nxt.req    = 1'b0;
                    r_nxt.src[c] = step(r.src[c], src_mode_in[c]);
                    r_nxt.st     = ST_RCAP;
                end
            end
            // read data arrives, store into buffer
            ST_RCAP: begin
                buf_we = 1'b1;
                if (r.idx == r.last) begin
                    r_nxt.idx = 3'h0;
                    r_nxt.st  = ST_WPREP;
                end else begin
                    r_nxt.idx  = 3'(r.idx + 3'h1);
                    r_nxt.req  = 1'b1;
                    r_nxt.addr = r.src[c];
                    r_nxt.st   = ST_READ;
                end
            end
            // address the buffer byte
            ST_WPREP: begin
                r_nxt.st = ST_WLOAD;
            end
            // load write data, refuse nonvolatile destination
            ST_WLOAD: begin
                if (in_ee(r.dst[c])) begin
                    r_nxt.act[c] = 1'b0;
                    r_nxt.err[c] = 1'b1;
                    r_nxt.st     = ST_IDLE;
                end else begin
                    r_nxt.req   = 1'b1;
                    r_nxt.we    = 1'b1;
                    r_nxt.addr  = r.dst[c];
                    r_nxt.wdata = buf_rd;
                    r_nxt.st    = ST_WRITE;
                end
            end
            // write request stands until granted
            ST_WRITE: begin
                // one access per grant, then release
                if (bus_gnt_in) begin
                    r_nxt.req    = 1'b0;
                    r_nxt.we     = 1'b0;
                    r_nxt.dst[c] = step(r.dst[c], dst_mode_in[c]);
                    r_nxt.blk[c] = 17'(r.blk[c] - 17'h1);
                    r_nxt.idx    = 3'(r.idx + 3'h1);
                    r_nxt.st     = (r.idx == r.last) ? ST_IDLE : ST_WPREP;
                    if (r.blk[c] == 17'h1) begin
                        r_nxt.st = ST_IDLE;
                        if (r.rep[c] == 9'h1) begin
                            fin = 1'b1;
                        end else begin
                            r_nxt.rep[c] = 9'(r.rep[c] - 9'h1);
                            r_nxt.blk[c] = {~|cfg_blk_in[c], cfg_blk_in[c]};
                        end
                    end
                end
            end
        endcase
        // completion of the transaction in service
        if (fin) begin
            r_nxt.act[c] = 1'b0;
            r_nxt.done[c] = 1'b1;
            if (reload_in[c]) begin
                r_nxt.src[c] = cfg_src_in[c];
                r_nxt.dst[c] = cfg_dst_in[c];
            end
            if (link_in[c[1]] && !r.act[p]) begin
                r_nxt.act[p] = 1'b1;
                r_nxt.blk[p] = {~|cfg_blk_in[p], cfg_blk_in[p]};
                r_nxt.rep[p] = {~|cfg_rep_in[p], cfg_rep_in[p]};
            end
        end
        // triggers latch after the clear so none is lost
        r_nxt.pend = (r_nxt.pend | trig_hit) & r_nxt.act;
        buf_ra = (r.st == ST_WPREP) ? r.idx : 3'h0;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------------------------------
    // any data-space address, memory or register
    assign bus_req_out   = r.req;
    assign bus_we_out    = r.we;
    assign bus_addr_out  = r.addr;
    assign bus_wdata_out = r.wdata;
    assign busy_out      = r.act;
    assign done_out      = r.done;
    assign err_out       = r.err;
    assign cur_ch_out    = r.ch;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    req_hold_a: assert property (bus_req_out && !bus_gnt_in |=>
        bus_req_out && $stable(bus_addr_out) && $stable(bus_we_out))
        else $error("request dropped or changed before grant");
    req_release_a: assert property (bus_req_out && bus_gnt_in |=> !bus_req_out)
        else $error("request kept after grant");
    no_ee_write_a: assert property (bus_req_out && bus_we_out |-> !in_ee(bus_addr_out))
        else $error("write into nonvolatile window");
    burst_len_a: assert property (r.st == ST_WRITE |->
        r.last <= burst_last(burst_in[r.ch]))
        else $error("burst longer than configured");
    dst_step_a: assert property (r.st == ST_WRITE && bus_gnt_in && !fin
        && dst_mode_in[r.ch] == `AM_INC |=> r.dst[$past(r.ch)] == `AW'($past(bus_addr_out) + `AW'h1))
        else $error("destination did not increment");
    reload_a: assert property (fin && reload_in[r.ch] |=>
        r.src[$past(r.ch)] == $past(cfg_src_in[r.ch]) && !r.act[$past(r.ch)])
        else $error("source not restored at completion");
    done_set_a: assert property (fin |=> done_out[$past(r.ch)])
        else $error("done flag not set");
    link_a: assert property (fin && link_in[r.ch[1]] && !r.act[r.ch ^ 2'h1] |=>
        busy_out[$past(r.ch) ^ 2'h1])
        else $error("linked partner not armed");
    prio_fixed_a: assert property (r.st == ST_IDLE && !prio_rr_in && r.act[0] && r.pend[0]
        |=> r.ch == 2'h0 && r.st == ST_READ)
        else $error("fixed priority not obeyed");
    no_trig_idle_a: assert property (r.st == ST_IDLE && !(|(r.act & r.pend)) |=>
        !bus_req_out)
        else $error("transfer without trigger");
    arm_len_a: assert property (arm_in[0] && !r.act[0] |=>
        r.blk[0] == {~|$past(cfg_blk_in[0]), $past(cfg_blk_in[0])} && busy_out[0])
        else $error("block length not loaded on arm");

    burst8_c:   cover property (r.st == ST_WRITE && r.last == `BL_8 && bus_gnt_in);
    link_c:     cover property (fin && link_in[r.ch[1]]);
    ee_abort_c: cover property (r.st == ST_WLOAD && in_ee(r.dst[r.ch]));
    repeat_c:   cover property (r.st == ST_WRITE && bus_gnt_in && r.blk[r.ch] == 17'h1
                                && r.rep[r.ch] > 9'h1);

endmodule

// File: verif/bus_mem_model.sv
`timescale 1ns/1ps
`include "dma_defs.svh"
module bus_mem_model (
    // clock and reset
    input  wire logic           clk_in,
    input  wire logic           rst_b_in,
    // bus from the controller
    input  wire logic           bus_req_in,
    input  wire logic           bus_we_in,
    input  wire logic [`AW-1:0] bus_addr_in,
    input  wire logic [7:0]     bus_wdata_in,
    // cycles the processor holds the bus before each grant
    input  wire logic [1:0]     stall_in,
    // answers
    output logic                bus_gnt_out,
    output logic      [7:0]     bus_rdata_out
);
    logic [7:0] mem [0:65535]; // data space image
    logic [1:0] wait_r;        // cycles waited for this grant
    int         ee_writes;     // writes landing in nonvolatile window

    // image filled with a pattern of the address
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = a[7:0] ^ 8'h5a;
        end
    end

    assign bus_gnt_out = bus_req_in && (wait_r >= stall_in);

    // accesses; read data stands one cycle, then the released bus toggles
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_r <= 2'h0;
            bus_rdata_out <= 8'h00;
            ee_writes <= 0;
        end else begin
            bus_rdata_out <= ~bus_rdata_out;
            if (bus_gnt_out) begin
                wait_r <= 2'h0;
                if (bus_we_in) begin
                    mem[bus_addr_in] <= bus_wdata_in;
                    if (bus_addr_in >= `EE_FIRST && bus_addr_in <= `EE_LAST) begin
                        ee_writes <= ee_writes + 1;
                    end
                end else begin
                    bus_rdata_out <= mem[bus_addr_in];
                end
            end else if (bus_req_in) begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule

// File: verif/dma_controller_tb.sv
`timescale 1ns/1ps
`include "dma_defs.svh"
module dma_controller_tb;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                     clk_in = 1'b0;
    logic                     rst_b_in = 1'b0;
    logic [`NCH-1:0][`AW-1:0] cfg_src_in = '0;
    logic [`NCH-1:0][`AW-1:0] cfg_dst_in = '0;
    logic [`NCH-1:0][15:0]    cfg_blk_in = '0;
    logic [`NCH-1:0][7:0]     cfg_rep_in = '0;
    logic [`NCH-1:0][1:0]     src_mode_in = '0;
    logic [`NCH-1:0][1:0]     dst_mode_in = '0;
    logic [`NCH-1:0][1:0]     burst_in = '0;
    logic [`NCH-1:0]          reload_in = '0;
    logic [`NCH-1:0][1:0]     trig_sel_in = '0;
    logic [1:0]               link_in = 2'h0;
    logic                     prio_rr_in = 1'b0;
    logic [`NCH-1:0]          arm_in = '0;
    logic [`NCH-1:0]          sw_trig_in = '0;
    logic [`NCH-1:0][2:0]     chan_trig_in = '0;
    logic [`NCH-1:0]          done_clr_in = '0;
    logic [1:0]               stall = 2'h0;   // processor slot length
    logic                     bus_gnt_in;
    logic [7:0]               bus_rdata_in;
    logic                     bus_req_out;
    logic                     bus_we_out;
    logic [`AW-1:0]           bus_addr_out;
    logic [7:0]               bus_wdata_out;
    logic [`NCH-1:0]          busy_out;
    logic [`NCH-1:0]          done_out;
    logic [`NCH-1:0]          err_out;
    logic [1:0]               cur_ch_out;
    logic [15:0]              gnt_log [$];    // granted addresses in order
    int                       n_fail = 0;
    int                       samples_checked = 0;
    int                       cyc = 0;

    dma_controller i_dma_controller (
        .clk_in, .rst_b_in, .cfg_src_in, .cfg_dst_in, .cfg_blk_in, .cfg_rep_in,
        .src_mode_in, .dst_mode_in, .burst_in, .reload_in, .trig_sel_in, .link_in,
        .prio_rr_in, .arm_in, .sw_trig_in, .chan_trig_in, .done_clr_in, .bus_gnt_in,
        .bus_rdata_in, .bus_req_out, .bus_we_out, .bus_addr_out, .bus_wdata_out,
        .busy_out, .done_out, .err_out, .cur_ch_out
    );
    bus_mem_model i_bus_mem_model (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_req_in(bus_req_out),
        .bus_we_in(bus_we_out), .bus_addr_in(bus_addr_out), .bus_wdata_in(bus_wdata_out),
        .stall_in(stall), .bus_gnt_out(bus_gnt_in), .bus_rdata_out(bus_rdata_in)
    );

    // ----------------------------------------------------------------
    // clock, hang guard, grant log
    // ----------------------------------------------------------------
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (bus_req_out && bus_gnt_in) gnt_log.push_back(bus_addr_out);
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] sb(input logic [15:0] a);
        return {8'h00, a[7:0] ^ 8'h5a};
    endfunction
    function automatic logic [15:0] mem(input logic [15:0] a);
        return {8'h00, i_bus_mem_model.mem[a]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic setup(input int c, input logic [15:0] s, input logic [15:0] d,
                         input logic [15:0] n, input logic [7:0] r, input logic [1:0] sm,
                         input logic [1:0] dm, input logic [1:0] bu, input logic [1:0] ts,
                         input logic rl);
        cfg_src_in[c] = s;
        cfg_dst_in[c] = d;
        cfg_blk_in[c] = n;
        cfg_rep_in[c] = r;
        src_mode_in[c] = sm;
        dst_mode_in[c] = dm;
        burst_in[c] = bu;
        trig_sel_in[c] = ts;
        reload_in[c] = rl;
    endtask
    // one-cycle strobes
    task automatic arm(input logic [3:0] m);
        @(negedge clk_in);
        arm_in = m;
        @(negedge clk_in);
        arm_in = '0;
    endtask
    task automatic clr(input logic [3:0] m);
        @(negedge clk_in);
        done_clr_in = m;
        @(negedge clk_in);
        done_clr_in = '0;
    endtask
    // trigger on the selected source, then wait for the bus to fall quiet
    task automatic fire(input logic [3:0] m);
        int idle;
        @(negedge clk_in);
        for (int c = 0; c < 4; c++) begin
            if (m[c] && trig_sel_in[c] == `TRIG_SW) sw_trig_in[c] = 1'b1;
            else if (m[c]) chan_trig_in[c][trig_sel_in[c] - 2'h1] = 1'b1;
        end
        @(negedge clk_in);
        sw_trig_in = '0;
        chan_trig_in = '0;
        idle = 0;
        while (idle < 8) begin
            @(negedge clk_in);
            idle = bus_req_out ? 0 : idle + 1;
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'b1;
        // every burst length, grants slowed by 0..3 cycles
        for (int b = 0; b < 4; b++) begin
            stall = b[1:0];
            setup(2, 16'h0400, 16'h2300 + 16'(b * 16), 16'h0008, 8'h01, `AM_INC, `AM_INC,
                  b[1:0], `TRIG_SW, 1'b0);
            arm(4'h4);
            for (int n = 0; n < (8 >> b); n++) begin
                check(busy_out[2], 1'b1);
                fire(4'h4);
            end
            check(done_out[2], 1'b1);
            check(busy_out[2], 1'b0);
            for (int i = 0; i < 8; i++) begin
                check(mem(16'h2300 + 16'(b * 16 + i)), sb(16'h0400 + 16'(i)));
            end
            clr(4'h4);
            check(done_out[2], 1'b0);
        end
        // each trigger source; two blocks, burst cut at block end
        stall = 2'h1;
        for (int t = 0; t < 4; t++) begin
            setup(3, 16'h0505, 16'h2400 + 16'(t), 16'h0003, 8'h02, `AM_DEC, `AM_STATIC,
                  2'h1, t[1:0], 1'b0);
            fire(4'h8);
            arm(4'h8);
            repeat (6) @(negedge clk_in);
            check(bus_req_out, 1'b0);
            for (int n = 0; n < 4; n++) begin
                check(done_out[3], 1'b0);
                fire(4'h8);
            end
            check(done_out[3], 1'b1);
            check(mem(16'h2400 + 16'(t)), sb(16'h0500));
            clr(4'h8);
        end
        // nonvolatile window: read allowed, write refused
        setup(3, `EE_FIRST, 16'h2500, 16'h0001, 8'h01, `AM_INC, `AM_INC, 2'h0, `TRIG_SW, 1'b0);
        arm(4'h8);
        fire(4'h8);
        check(mem(16'h2500), sb(`EE_FIRST));
        setup(3, 16'h0100, `EE_FIRST + 16'h0800, 16'h0001, 8'h01, `AM_INC, `AM_INC, 2'h0,
              `TRIG_SW, 1'b0);
        arm(4'h8);
        fire(4'h8);
        check(err_out[3], 1'b1);
        check(busy_out[3], 1'b0);
        check(16'(i_bus_mem_model.ee_writes), 16'h0000);
        // fixed priority, then round robin
        setup(2, 16'h0600, 16'h2600, 16'h0001, 8'h01, `AM_INC, `AM_INC, 2'h0, `TRIG_SW, 1'b0);
        setup(3, 16'h0700, 16'h2700, 16'h0001, 8'h01, `AM_INC, `AM_INC, 2'h0, `TRIG_SW, 1'b0);
        arm(4'hc);
        gnt_log.delete();
        fire(4'hc);
        check(gnt_log[0], 16'h0600);
        check(gnt_log[1], 16'h2600);
        check(gnt_log[2], 16'h0700);
        check(cur_ch_out, 2'h3);
        prio_rr_in = 1'b1;
        arm(4'hc);
        fire(4'h4);
        arm(4'h4);
        gnt_log.delete();
        fire(4'hc);
        check({8'h00, gnt_log[0][15:8]}, 16'h0007);
        // linked pair, reload on one side only
        prio_rr_in = 1'b0;
        setup(0, 16'h0200, 16'h2100, 16'h0002, 8'h01, `AM_INC, `AM_INC, 2'h1, `TRIG_SW, 1'b1);
        setup(1, 16'h0300, 16'h2200, 16'h0002, 8'h01, `AM_INC, `AM_INC, 2'h1, `TRIG_SW, 1'b1);
        // a linked partner keeps its own addresses: one unlinked run with reload primes ch1
        arm(4'h2);
        fire(4'h2);
        reload_in[1] = 1'b0;
        i_bus_mem_model.mem[16'h2201] = 8'h00;
        link_in = 2'h1;
        arm(4'h1);
        fire(4'h1);
        check(busy_out[1], 1'b1);
        fire(4'h2);
        check(mem(16'h2201), sb(16'h0301));
        check(busy_out[0], 1'b1);
        i_bus_mem_model.mem[16'h2100] = 8'h00;
        fire(4'h1);
        check(mem(16'h2100), sb(16'h0200));
        fire(4'h2);
        check(mem(16'h2203), sb(16'h0303));
        stop_test();
    end
endmodule
